//--- rtl/dmms_top.sv
// Mode selection and supervision of a DMX-controlled rotating shaft unit, with APB registers.
// Assumes a DMX receiver giving decoded slots, a shaft position input and a home sensor.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dmms_map.svh"
module dmms_top
  import dmms_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = `DMMS_LOSS_CYC,
  parameter int unsigned FLASH_CYCLES = `DMMS_FLASH_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Local selectors and sensors
  input wire logic [3:0] mode_sel_i,
  input wire logic [9:0] addr_sel_i,
  input wire logic home_btn_i,
  input wire logic home_sensor_i,
  input wire logic pwr_fail_i,
  input wire logic [15:0] shaft_pos_i,
  // Decoded DMX slots
  input wire logic slot_valid_i,
  input wire logic [9:0] slot_num_i,
  input wire logic [7:0] slot_data_i,
  input wire logic frame_end_i,
  input wire logic frame_err_i,
  // Motor drive and indicators
  output logic motor_en_o,
  output logic motor_dir_cw_o,
  output logic [15:0] motor_speed_o,
  output logic [15:0] target_pos_o,
  output logic dmx_led_o,
  output logic homed_o
);
  logic [1:0] rst_sync;
  logic rst_n;
  dmms_chan_t chan;
  logic frame_ok;
  logic [27:0] loss_cnt;
  logic link_ok;
  logic lost_flag;
  logic [27:0] flash_cnt;
  logic flash;
  logic ctrl_auto;
  logic home_req;
  dmms_home_st_t home_st;
  logic homed;
  logic home_start;
  dmms_kind_t kind;
  logic [15:0] step;
  logic blackout;
  logic req_cw;
  logic [15:0] req_speed;
  logic dir_cw;
  logic [15:0] ramp_target;
  logic hard_stop;
  logic [15:0] speed;
  logic apb_wr;
  logic apb_setup;
  logic addr_hit;
  logic [31:0] next_rdata;

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  dmms_chan_cap u_cap (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .start_addr_i(addr_sel_i),
    .slot_valid_i(slot_valid_i),
    .slot_num_i(slot_num_i),
    .slot_data_i(slot_data_i),
    .frame_end_i(frame_end_i),
    .frame_err_i(frame_err_i),
    .chan_o(chan),
    .frame_ok_o(frame_ok)
  );

  // Link watchdog: restarted by every good frame of our block
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt <= 28'h0000000;
      link_ok <= 1'b0;
    end else if (ce_i) begin
      if (frame_ok) begin
        loss_cnt <= 28'h0000000;
        link_ok <= 1'b1;
      end else if (loss_cnt >= 28'(LOSS_CYCLES - 1)) begin
        link_ok <= 1'b0;
      end else begin
        loss_cnt <= loss_cnt + 28'h0000001;
      end
    end
  end

  // Sticky loss flag; a new loss in the clearing cycle still sets it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lost_flag <= 1'b0;
    end else if (ce_i) begin
      if (link_ok && loss_cnt >= 28'(LOSS_CYCLES - 1) && !frame_ok) begin
        lost_flag <= 1'b1;
      end else if (apb_wr && paddr_i == `DMMS_REG_STATUS && pwdata_i[`DMMS_ST_LOST]) begin
        lost_flag <= 1'b0;
      end
    end
  end

  // LED blink timebase
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt <= 28'h0000000;
      flash <= 1'b0;
    end else if (ce_i) begin
      if (flash_cnt >= 28'(FLASH_CYCLES - 1)) begin
        flash_cnt <= 28'h0000000;
        flash <= !flash;
      end else begin
        flash_cnt <= flash_cnt + 28'h0000001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dmx_led_o <= 1'b0;
    end else if (ce_i) begin
      dmx_led_o <= link_ok ? 1'b1 : flash;
    end
  end

  // Mode from the local selector only
  always_comb begin
    case (mode_sel_i)
      `DMMS_SEL_POS_SLOW: begin
        kind = MK_POS;
        step = `DMMS_STEP_SLOW;
      end
      `DMMS_SEL_POS_MED: begin
        kind = MK_POS;
        step = `DMMS_STEP_MED;
      end
      `DMMS_SEL_POS_FAST: begin
        kind = MK_POS;
        step = `DMMS_STEP_FAST;
      end
      `DMMS_SEL_MAN_CW: begin
        kind = MK_CW;
        step = `DMMS_STEP_MED;
      end
      `DMMS_SEL_MAN_CCW: begin
        kind = MK_CCW;
        step = `DMMS_STEP_MED;
      end
      default: begin
        kind = MK_NEUTRAL;
        step = `DMMS_STEP_MED;
      end
    endcase
  end

  // Position reset: manual button, software request or automatic on entering positioning
  assign home_start = (home_btn_i || home_req || (ctrl_auto && !homed)) && kind == MK_POS;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      home_st <= HOME_IDLE;
    end else if (ce_i) begin
      case (home_st)
        HOME_IDLE: begin
          if (home_start && !pwr_fail_i) begin
            home_st <= HOME_SEEK;
          end
        end
        HOME_SEEK: begin
          if (pwr_fail_i || kind != MK_POS || home_sensor_i) begin
            home_st <= HOME_IDLE;
          end
        end
        default: begin
          home_st <= HOME_IDLE;
        end
      endcase
    end
  end

  // Cleared at power-up by reset and on any supply loss
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      homed <= 1'b0;
    end else if (ce_i) begin
      if (pwr_fail_i) begin
        homed <= 1'b0;
      end else if (home_st == HOME_SEEK && home_sensor_i) begin
        homed <= 1'b1;
      end
    end
  end
  assign homed_o = homed;

  // Desk blackout: every channel of the block at zero
  assign blackout = (chan == '0);

  // Requested direction and speed per mode
  always_comb begin
    req_cw = 1'b1;
    req_speed = 16'h0000;
    hard_stop = 1'b0;
    case (kind)
      MK_CW: begin
        req_cw = 1'b1;
        req_speed = {addr_sel_i, 6'h00};
      end
      MK_CCW: begin
        req_cw = 1'b0;
        req_speed = {addr_sel_i, 6'h00};
      end
      MK_POS: begin
        if (home_st == HOME_SEEK) begin
          req_cw = 1'b1;
          req_speed = `DMMS_HOME_SPEED;
        end else if (!homed) begin
          hard_stop = 1'b1;
        end else if (!link_ok || blackout || chan.speed_lim == 8'h00) begin
          hard_stop = 1'b1;
        end else begin
          req_cw = chan.target_pos > shaft_pos_i;
          req_speed = (chan.target_pos == shaft_pos_i) ? 16'h0000 : {chan.speed_lim, 8'h00};
        end
      end
      default: begin
        hard_stop = 1'b1;
      end
    endcase
  end

  // Reversal only after the ramp has brought the shaft to rest
  assign ramp_target = (req_cw != dir_cw) ? 16'h0000 : req_speed;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_cw <= 1'b1;
    end else if (ce_i) begin
      if (speed == 16'h0000) begin
        dir_cw <= req_cw;
      end
    end
  end

  dmms_ramp u_ramp (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .stop_i(hard_stop),
    .target_i(ramp_target),
    .step_i(step),
    .speed_o(speed)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      motor_en_o <= 1'b0;
      motor_dir_cw_o <= 1'b1;
      motor_speed_o <= 16'h0000;
      target_pos_o <= 16'h0000;
    end else if (ce_i) begin
      motor_en_o <= !hard_stop;
      motor_dir_cw_o <= dir_cw;
      motor_speed_o <= hard_stop ? 16'h0000 : speed;
      target_pos_o <= chan.target_pos;
    end
  end

  // APB slave: zero wait states while enabled; stalls when the clock enable is low
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pwrite_i && ce_i;
  assign addr_hit = paddr_i == `DMMS_REG_CTRL || paddr_i == `DMMS_REG_STATUS ||
                    paddr_i == `DMMS_REG_TARGET || paddr_i == `DMMS_REG_SPEED ||
                    paddr_i == `DMMS_REG_CHAN;
  assign pready_o = ce_i;
  assign pslverr_o = psel_i && penable_i && !addr_hit;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_auto <= `DMMS_CTRL_RST;
      home_req <= 1'b0;
    end else if (ce_i) begin
      home_req <= 1'b0;
      if (apb_wr && paddr_i == `DMMS_REG_CTRL) begin
        ctrl_auto <= pwdata_i[`DMMS_CTRL_AUTO];
        home_req <= pwdata_i[`DMMS_CTRL_HOME];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    case (paddr_i)
      `DMMS_REG_CTRL: next_rdata[`DMMS_CTRL_AUTO] = ctrl_auto;
      `DMMS_REG_STATUS: begin
        next_rdata[`DMMS_ST_HOMED] = homed;
        next_rdata[`DMMS_ST_LINK] = link_ok;
        next_rdata[`DMMS_ST_LOST] = lost_flag;
        next_rdata[`DMMS_ST_MOTOR] = motor_en_o;
        next_rdata[`DMMS_ST_DIR] = dir_cw;
        next_rdata[`DMMS_ST_HOMING] = home_st == HOME_SEEK;
        next_rdata[`DMMS_ST_MODE +: 4] = mode_sel_i;
      end
      `DMMS_REG_TARGET: next_rdata[15:0] = chan.target_pos;
      `DMMS_REG_SPEED: next_rdata[15:0] = speed;
      `DMMS_REG_CHAN: next_rdata = {chan.speed_lim, chan.cw_ch, chan.ccw_ch, chan.mode_ch};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_o <= 32'h00000000;
    end else if (ce_i && apb_setup) begin
      prdata_o <= next_rdata;
    end
  end
endmodule
`default_nettype wire

//--- rtl/dmms_map.svh
// Address map, field positions, reset values and timing counts of the motion mode selector.
// Included by dmms_top, dmms_chan_cap, the checker and the testbench; holds definitions only.
`ifndef DMMS_MAP_SVH
`define DMMS_MAP_SVH

// APB register byte offsets
`define DMMS_REG_CTRL 8'h00
`define DMMS_REG_STATUS 8'h04
`define DMMS_REG_TARGET 8'h08
`define DMMS_REG_SPEED 8'h0c
`define DMMS_REG_CHAN 8'h10

// CTRL fields
`define DMMS_CTRL_AUTO 0
`define DMMS_CTRL_HOME 1
`define DMMS_CTRL_RST 1'b1

// STATUS fields
`define DMMS_ST_HOMED 0
`define DMMS_ST_LINK 1
`define DMMS_ST_LOST 2
`define DMMS_ST_MOTOR 3
`define DMMS_ST_DIR 4
`define DMMS_ST_HOMING 5
`define DMMS_ST_MODE 8

// Mode selector positions
`define DMMS_SEL_POS_SLOW 4'h1
`define DMMS_SEL_POS_MED 4'h2
`define DMMS_SEL_POS_FAST 4'h3
`define DMMS_SEL_MAN_CW 4'h7
`define DMMS_SEL_MAN_CCW 4'h8

// Channel block
`define DMMS_NUM_CH 6
`define DMMS_ADDR_MIN 10'h001
`define DMMS_ADDR_MAX 10'h1f9

// Speed ramp steps per clock, slow smallest, and the homing speed
`define DMMS_STEP_SLOW 16'h0004
`define DMMS_STEP_MED 16'h0010
`define DMMS_STEP_FAST 16'h0040
`define DMMS_HOME_SPEED 16'h2000

// Timing
`define DMMS_CLK_MHZ 250
`define DMMS_LOSS_MS 1000
`define DMMS_FLASH_MS 250
`define DMMS_LOSS_CYC (`DMMS_LOSS_MS * 1000 * `DMMS_CLK_MHZ)
`define DMMS_FLASH_CYC (`DMMS_FLASH_MS * 1000 * `DMMS_CLK_MHZ)

`endif

//--- rtl/dmms_pkg.sv
// Types shared by the motion mode selector files.
// Assumes the constants of dmms_map.svh for all numbers.
package dmms_pkg;

  typedef struct packed {
    logic [15:0] target_pos;
    logic [7:0] speed_lim;
    logic [7:0] cw_ch;
    logic [7:0] ccw_ch;
    logic [7:0] mode_ch;
  } dmms_chan_t;

  typedef enum logic [1:0] {MK_NEUTRAL, MK_POS, MK_CW, MK_CCW} dmms_kind_t;

  typedef enum logic {HOME_IDLE, HOME_SEEK} dmms_home_st_t;

endpackage

//--- rtl/dmms_chan_cap.sv
// Captures the six DMX slots of this unit's channel block and commits them per good frame.
// Assumes a DMX receiver delivering decoded slots, numbered from 1, plus a frame-end strobe.
`timescale 1ns/1ps
`default_nettype none
`include "dmms_map.svh"
module dmms_chan_cap
  import dmms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [9:0] start_addr_i,
  input wire logic slot_valid_i,
  input wire logic [9:0] slot_num_i,
  input wire logic [7:0] slot_data_i,
  input wire logic frame_end_i,
  input wire logic frame_err_i,
  output dmms_chan_t chan_o,
  output logic frame_ok_o
);
  logic [7:0] shadow [`DMMS_NUM_CH];
  logic [`DMMS_NUM_CH-1:0] seen;
  logic addr_ok;

  assign addr_ok = (start_addr_i >= `DMMS_ADDR_MIN) && (start_addr_i <= `DMMS_ADDR_MAX);

  // Only slots of our own block are taken; units on the same address act alike
  genvar i;
  generate
    for (i = 0; i < `DMMS_NUM_CH; i++) begin : g_slot
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          shadow[i] <= 8'h00;
          seen[i] <= 1'b0;
        end else if (ce_i) begin
          if (frame_end_i) begin
            seen[i] <= 1'b0;
          end else if (slot_valid_i && addr_ok &&
                       slot_num_i == start_addr_i + 10'(i)) begin
            shadow[i] <= slot_data_i;
            seen[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chan_o <= '0;
      frame_ok_o <= 1'b0;
    end else if (ce_i) begin
      frame_ok_o <= frame_end_i && !frame_err_i && (&seen);
      if (frame_end_i && !frame_err_i && (&seen)) begin
        chan_o.target_pos <= {shadow[0], shadow[1]};
        chan_o.speed_lim <= shadow[2];
        chan_o.cw_ch <= shadow[3];
        chan_o.ccw_ch <= shadow[4];
        chan_o.mode_ch <= shadow[5];
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/dmms_ramp.sv
// Rate limiter: moves the speed command toward its target by at most one step per clock.
// Assumes the caller picks the step; a stop input zeroes the command at once.
`timescale 1ns/1ps
`default_nettype none
module dmms_ramp (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic stop_i,
  input wire logic [15:0] target_i,
  input wire logic [15:0] step_i,
  output logic [15:0] speed_o
);
  logic [16:0] up;
  logic [16:0] down;

  assign up = {1'b0, speed_o} + {1'b0, step_i};
  assign down = {1'b0, speed_o} - {1'b0, step_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_o <= 16'h0000;
    end else if (ce_i) begin
      if (stop_i) begin
        speed_o <= 16'h0000;
      end else if (speed_o < target_i) begin
        speed_o <= (up[16] || up[15:0] > target_i) ? target_i : up[15:0];
      end else if (speed_o > target_i) begin
        speed_o <= (down[16] || down[15:0] < target_i) ? target_i : down[15:0];
      end
    end
  end
endmodule
`default_nettype wire

//--- test/dmms_props.sv
// Checker for the motion mode selector top: bus answers, stop modes, ramp limits, commits.
// Assumes it is bound to dmms_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "dmms_map.svh"
module dmms_props
  import dmms_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = 200,
  parameter int unsigned FLASH_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [3:0] mode_sel_i,
  input wire logic pwr_fail_i,
  input wire logic frame_end_i,
  input wire logic frame_err_i,
  input wire logic motor_en_o,
  input wire logic motor_dir_cw_o,
  input wire logic [15:0] motor_speed_o,
  input wire logic [15:0] target_pos_o,
  input wire logic homed_o
);
  logic mapped;
  logic neut;
  logic good_end;
  assign mapped = paddr_i inside {`DMMS_REG_CTRL, `DMMS_REG_STATUS, `DMMS_REG_TARGET,
                                  `DMMS_REG_SPEED, `DMMS_REG_CHAN};
  assign neut = mode_sel_i inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h9};
  assign good_end = frame_end_i && !frame_err_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_pready_ce: assert property (psel_i |-> pready_o == ce_i)
    else $error("pready does not follow clock enable");
  chk_unmapped_err: assert property (psel_i && penable_i && !mapped |-> pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel_i && penable_i && mapped |-> !pslverr_o)
    else $error("mapped access refused");
  // Read data may only move after a setup cycle, so it stands through the access phase
  chk_prdata_stands: assert property ($changed(prdata_o) |-> $past(psel_i && !penable_i && ce_i))
    else $error("read data moved outside a setup cycle");
  chk_neutral_still: assert property (neut [*3] |-> !motor_en_o && motor_speed_o == 16'h0000)
    else $error("motor active in neutral position");
  chk_dir_at_rest: assert property ($changed(motor_dir_cw_o) |-> $past(motor_speed_o) == 0)
    else $error("direction changed while turning");
  chk_ramp_bound: assert property (motor_speed_o != 0 |->
    (motor_speed_o - $past(motor_speed_o) <= 16'h0040 || $past(motor_speed_o) - motor_speed_o <= 16'h0040))
    else $error("speed step above fast limit");
  chk_slow_ramp: assert property (mode_sel_i == 1 && $past(mode_sel_i) == 1 && $past(mode_sel_i, 2) == 1
    && homed_o && $past(homed_o, 2) && motor_speed_o != 0 |->
    (motor_speed_o - $past(motor_speed_o) <= `DMMS_STEP_SLOW ||
     $past(motor_speed_o) - motor_speed_o <= `DMMS_STEP_SLOW))
    else $error("slow mode step too large");
  chk_pwr_clears: assert property (pwr_fail_i [*2] |-> !homed_o)
    else $error("homed kept through supply loss");
  chk_target_commit: assert property ($changed(target_pos_o) |-> $past(good_end) || $past(good_end, 2))
    else $error("target changed without a good frame");
endmodule
bind dmms_top dmms_props #(.LOSS_CYCLES(LOSS_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .mode_sel_i(mode_sel_i), .pwr_fail_i(pwr_fail_i), .frame_end_i(frame_end_i),
  .frame_err_i(frame_err_i), .motor_en_o(motor_en_o), .motor_dir_cw_o(motor_dir_cw_o),
  .motor_speed_o(motor_speed_o), .target_pos_o(target_pos_o), .homed_o(homed_o));
`default_nettype wire

//--- test/dmms_desk.sv
// Behavioural lighting desk: sends one frame of six slots from a start address, then an end strobe.
// Assumes the receiver in front of the block already decoded slots; idle data lines wander.
`timescale 1ns/1ps
`default_nettype none
module dmms_desk (
  input wire logic clk_i,
  output logic slot_valid_o,
  output logic [9:0] slot_num_o,
  output logic [7:0] slot_data_o,
  output logic frame_end_o,
  output logic frame_err_o
);
  initial begin
    slot_valid_o = 1'b0;
    slot_num_o = 10'h000;
    slot_data_o = 8'h00;
    frame_end_o = 1'b0;
    frame_err_o = 1'b0;
  end
  // A zero in the third byte is the desk's speed stop control
  task automatic send(input logic [9:0] s, input logic [47:0] d, input logic err);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      slot_valid_o <= 1'b1;
      slot_num_o <= s + 10'(i);
      slot_data_o <= d[47 - 8 * i -: 8];
    end
    @(posedge clk_i);
    slot_valid_o <= 1'b0;
    slot_data_o <= ~slot_data_o;
    slot_num_o <= ~slot_num_o;
    frame_end_o <= 1'b1;
    frame_err_o <= err;
    @(posedge clk_i);
    frame_end_o <= 1'b0;
    frame_err_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Testbench of the motion mode selector: APB register access, selector modes and desk frames.
// Assumes short loss and flash counts so that signal loss is reached quickly.
`timescale 1ns/1ps
`default_nettype none
`include "dmms_map.svh"
module tb;
  import dmms_pkg::*;
  localparam int LOSS = 2000;
  localparam int FLASH = 20;
  logic clk_i = 0, nrst_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic pready_o, pslverr_o, e, home_btn_i = 0, home_sensor_i = 0, pwr_fail_i = 0;
  logic [3:0] mode_sel_i = 4'h0;
  logic [9:0] addr_sel_i = 10'h00a, slot_num_i;
  logic [15:0] shaft_pos_i = 16'h0000, motor_speed_o, target_pos_o, s0;
  logic slot_valid_i, frame_end_i, frame_err_i;
  logic [7:0] slot_data_i;
  logic motor_en_o, motor_dir_cw_o, dmx_led_o, homed_o, l;
  int error_cnt = 0, compares = 0, tog;
  always #2 clk_i = ~clk_i;
  dmms_top #(.LOSS_CYCLES(LOSS), .FLASH_CYCLES(FLASH)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mode_sel_i(mode_sel_i), .addr_sel_i(addr_sel_i), .home_btn_i(home_btn_i),
    .home_sensor_i(home_sensor_i), .pwr_fail_i(pwr_fail_i), .shaft_pos_i(shaft_pos_i),
    .slot_valid_i(slot_valid_i), .slot_num_i(slot_num_i), .slot_data_i(slot_data_i),
    .frame_end_i(frame_end_i), .frame_err_i(frame_err_i), .motor_en_o(motor_en_o),
    .motor_dir_cw_o(motor_dir_cw_o), .motor_speed_o(motor_speed_o),
    .target_pos_o(target_pos_o), .dmx_led_o(dmx_led_o), .homed_o(homed_o));
  dmms_desk u_desk (.clk_i(clk_i), .slot_valid_o(slot_valid_i), .slot_num_o(slot_num_i),
    .slot_data_o(slot_data_i), .frame_end_o(frame_end_i), .frame_err_o(frame_err_i));
  task automatic conclude();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; conclude(); end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask
  function automatic logic cond(input int k, input logic [15:0] s, input logic d);
    case (k)
      0: return homed_o === 1'b1;
      1: return motor_en_o === 1'b1;
      2: return motor_en_o === 1'b0;
      default: return motor_speed_o === s && motor_dir_cw_o === d;
    endcase
  endfunction
  // Bounded wait; a run-out counts as a mismatch and ends the run
  task automatic wt(input int k, input logic [15:0] s = 0, input logic d = 0);
    int n;
    n = 0;
    while (!cond(k, s, d) && n < 6000) begin @(posedge clk_i); n++; end
    if (n >= 6000) begin error_cnt++; conclude(); end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1;
    repeat (3) @(posedge clk_i);
    apb(0, `DMMS_REG_CTRL, 0); chk(r, 32'h1);
    apb(0, 8'h14, 0); chk({31'h0, e}, 32'h1); chk(r, 32'h0);
    for (int i = 0; i < 5; i++) begin
      mode_sel_i <= (i == 0) ? 4'h0 : (i == 4) ? 4'h9 : 4'(i + 3);
      u_desk.send(10'h00a, 48'h0000_8000_0000, 0);
      repeat (4) @(posedge clk_i);
      chk({motor_en_o, motor_speed_o}, 0);
    end
    mode_sel_i <= `DMMS_SEL_MAN_CW; addr_sel_i <= 10'd100;
    wt(3, 16'h1900, 1); chk(motor_en_o, 1);
    addr_sel_i <= 10'd500; repeat (4) @(posedge clk_i); ce_i <= 0;
    // Clock enable low must freeze the ramp mid-way
    @(posedge clk_i); s0 = motor_speed_o; repeat (8) @(posedge clk_i);
    chk(motor_speed_o, s0); ce_i <= 1;
    wt(3, 16'h7d00, 1);
    mode_sel_i <= `DMMS_SEL_MAN_CCW; addr_sel_i <= 10'd100;
    wt(3, 16'h1900, 0); chk(motor_en_o, 1);
    apb(0, `DMMS_REG_STATUS, 0); chk(r[1], 0);
    addr_sel_i <= 10'h00a; mode_sel_i <= `DMMS_SEL_POS_SLOW;
    u_desk.send(10'h00a, 48'h1234_8000_0000, 0); repeat (3) @(posedge clk_i);
    chk({target_pos_o, dmx_led_o}, {16'h1234, 1'b1});
    apb(1, `DMMS_REG_STATUS, 32'h4);
    repeat (4) @(posedge clk_i); chk(homed_o, 0);
    home_sensor_i <= 1; wt(0); home_sensor_i <= 0;
    wt(1);
    apb(0, `DMMS_REG_STATUS, 0); chk(r & 32'hf07, 32'h103);
    for (int m = 2; m < 4; m++) begin
      mode_sel_i <= 4'(m); u_desk.send(10'h00a, 48'h1234_8000_0000, 0);
      wt(1); s0 = motor_speed_o; repeat (8) @(posedge clk_i);
      chk(motor_speed_o - s0, 8 * ((m == 2) ? `DMMS_STEP_MED : `DMMS_STEP_FAST));
    end
    u_desk.send(10'h014, 48'h5555_8000_0000, 0); repeat (3) @(posedge clk_i);
    chk(target_pos_o, 16'h1234);
    u_desk.send(10'h00a, 48'h5555_8000_0000, 1); repeat (3) @(posedge clk_i);
    chk(target_pos_o, 16'h1234);
    addr_sel_i <= 10'd505;
    u_desk.send(10'd505, 48'h4321_8000_0000, 0); repeat (3) @(posedge clk_i);
    chk(target_pos_o, 16'h4321);
    u_desk.send(10'd505, 48'h4321_0000_0000, 0); wt(2);
    u_desk.send(10'd505, 48'h4321_8000_0000, 0); wt(1);
    u_desk.send(10'd505, 48'h0, 0); wt(2);
    u_desk.send(10'd505, 48'h4321_8000_0000, 0); wt(1);
    wt(2);
    apb(0, `DMMS_REG_STATUS, 0); chk(r[2], 1);
    tog = 0; l = dmx_led_o;
    repeat (5 * FLASH) begin @(posedge clk_i); tog += (dmx_led_o !== l); l = dmx_led_o; end
    chk(tog >= 3, 1);
    apb(1, `DMMS_REG_CTRL, 32'h0); apb(0, `DMMS_REG_CTRL, 0); chk(r, 32'h0);
    pwr_fail_i <= 1; repeat (3) @(posedge clk_i); chk(homed_o, 0);
    pwr_fail_i <= 0; home_sensor_i <= 1; repeat (4) @(posedge clk_i); chk(homed_o, 0);
    home_btn_i <= 1; @(posedge clk_i); home_btn_i <= 0; wt(0);
    pwr_fail_i <= 1; @(posedge clk_i); pwr_fail_i <= 0;
    apb(1, `DMMS_REG_CTRL, 32'h2); chk(homed_o, 0); wt(0);
    conclude();
  end
endmodule
`default_nettype wire
